// ==== design/list_seq_pkg.sv ====
// shared constants for the list step sequencer
package list_seq_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CMD_OFS = 12'h004;
  localparam logic [11:0] PASS_OFS = 12'h008;
  localparam logic [11:0] SKIP_OFS = 12'h00C;
  localparam logic [11:0] HOLD_WR_OFS = 12'h010;
  localparam logic [11:0] FILL_PTR_OFS = 12'h014;
  localparam logic [11:0] RDPTR_OFS = 12'h018;
  localparam logic [11:0] STATUS_OFS = 12'h01C;
  localparam logic [11:0] STEP_LEN_OFS = 12'h020;
  localparam logic [11:0] HOLD_RD_OFS = 12'h040;
  localparam logic [11:0] HOLD_RD_END = 12'h07C;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int CMD_RUN_BIT = 2;
  localparam int CMD_STOP_BIT = 3;
  // ---------------------------------------------------------------
  // depths, defaults and timing
  // ---------------------------------------------------------------
  localparam int TABLE_DEPTH = 1002;
  localparam int PTR_W = 10;
  localparam int HOLD_W = 16;
  localparam int READ_WINDOW = 16;
  localparam logic [7:0] PASS_DEFAULT = 8'h01;
  localparam logic [7:0] SKIP_DEFAULT = 8'h00;
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_US = 500;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage

// ==== design/time_base.sv ====
// time base: one-cycle tick every period
`timescale 1ns/1ps
module time_base #(
  parameter int PERIOD = list_seq_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0] count;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (restart) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == CW'(PERIOD - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// ==== design/hold_table.sv ====
// dwell memory: one write port, one registered read port
`timescale 1ns/1ps
module hold_table #(
  parameter int DEPTH = list_seq_pkg::TABLE_DEPTH,
  parameter int AW = list_seq_pkg::PTR_W,
  parameter int DW = list_seq_pkg::HOLD_W
) (
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ==== design/list_step_sequencer.sv ====
// list step sequencer with apb register slave
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
// Behaviour
// [RQ1] run list first-to-last when up, last-to-first when down
// [RQ2] reset or clear command forces direction to up
// [RQ3] direction applies to default order and user-defined order alike
// [RQ4] direction reads back as stored up or down value
// [RQ5] host supplies dwell 0.0005 to 10 s, at most 1002 entries
// [RQ6] dwell entry at index i times the step at index i
// [RQ7] only location 0 written means its dwell serves every step
// [RQ8] dwell readout gives 16 values from the readout start pointer
// [RQ9] fill pointer 0..1001 counts written dwell entries, next write index; code lets it reach 1002 after the 1002nd write
// [RQ10] clear sets every table pointer to zero
// [RQ11] run command starts list at its first step in chosen direction
// [RQ12] last step goes directly to first step at pass end
// [RQ13] after all passes stop and hold last executed step
// [RQ14] down direction finishes holding location 0
// [RQ15] skip one runs first step only in the first pass
// [RQ16] run time is passes times steps times dwell plus skipped once
// [RQ17] pass count zero repeats until stop command
// [RQ18] skipping applies only in up direction
// [RQ19] clear also selects natural order and pass count one
// [RQ20] dwell timer counts ticks and advances at the step dwell
module list_step_sequencer #(
  parameter int TICK_PERIOD = list_seq_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic running,
  output logic [9:0] stepIndex,
  output logic stepStrobe
);
  localparam int AW = list_seq_pkg::PTR_W;
  localparam int DW = list_seq_pkg::HOLD_W;
  localparam logic [AW-1:0] LAST_IDX = AW'(list_seq_pkg::TABLE_DEPTH - 1);

  typedef enum logic [1:0] {IDLE, LOAD, DWELL} seq_state_t;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic setup;
  logic wrCycle;
  logic rdCycle;
  logic inWindow;
  assign setup = psel && !penable;
  assign wrCycle = psel && penable && pready && pwrite;
  assign rdCycle = psel && penable && pready && !pwrite;
  assign inWindow = paddr >= list_seq_pkg::HOLD_RD_OFS && paddr <= list_seq_pkg::HOLD_RD_END;

  logic cmdReset;
  logic cmdClear;
  logic cmdRun;
  logic cmdStop;
  logic wrCmd;
  assign wrCmd = wrCycle && paddr == list_seq_pkg::CMD_OFS;
  assign cmdReset = wrCmd && pwdata[list_seq_pkg::CMD_RESET_BIT];
  assign cmdClear = wrCmd && pwdata[list_seq_pkg::CMD_CLEAR_BIT];
  assign cmdRun = wrCmd && pwdata[list_seq_pkg::CMD_RUN_BIT];
  assign cmdStop = wrCmd && pwdata[list_seq_pkg::CMD_STOP_BIT];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  list_seq_pkg::dir_t direction;
  logic userOrder;
  logic [7:0] passCount;
  logic [7:0] skipCount;
  logic [AW-1:0] fillPtr;
  logic [AW-1:0] readPtr;
  logic [AW-1:0] stepCount;

  // [RQ2] reset or clear forces up
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      direction <= list_seq_pkg::DIR_UP;
      userOrder <= 1'b0;
    end else if (cmdReset || cmdClear) begin
      direction <= list_seq_pkg::DIR_UP;
      // [RQ19] natural order again
      userOrder <= 1'b0;
    end else if (wrCycle && paddr == list_seq_pkg::CTRL_OFS) begin
      direction <= list_seq_pkg::dir_t'(pwdata[list_seq_pkg::CTRL_DIR_BIT]);
      userOrder <= pwdata[list_seq_pkg::CTRL_SRC_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      passCount <= list_seq_pkg::PASS_DEFAULT;
      skipCount <= list_seq_pkg::SKIP_DEFAULT;
    end else if (cmdReset || cmdClear) begin
      // [RQ19] pass count back to one
      passCount <= list_seq_pkg::PASS_DEFAULT;
      skipCount <= list_seq_pkg::SKIP_DEFAULT;
    end else if (wrCycle && paddr == list_seq_pkg::PASS_OFS) begin
      passCount <= pwdata[7:0];
    end else if (wrCycle && paddr == list_seq_pkg::SKIP_OFS) begin
      skipCount <= pwdata[7:0];
    end
  end

  // steps per pass stands for the setpoint table length, which lives elsewhere
  logic holdWr;
  assign holdWr = wrCycle && paddr == list_seq_pkg::HOLD_WR_OFS && fillPtr <= LAST_IDX;

  // [RQ10] clear zeroes every pointer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fillPtr <= '0;
      readPtr <= '0;
      stepCount <= '0;
    end else if (cmdReset || cmdClear) begin
      fillPtr <= '0;
      readPtr <= '0;
      stepCount <= '0;
    end else begin
      // [RQ9] fill pointer advances per write
      if (holdWr) begin
        fillPtr <= fillPtr + 1'b1;
      end
      if (wrCycle && paddr == list_seq_pkg::RDPTR_OFS) begin
        readPtr <= pwdata[AW-1:0];
      end
      if (wrCycle && paddr == list_seq_pkg::STEP_LEN_OFS) begin
        stepCount <= pwdata[AW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // dwell memory, shared between bus readout and the sequencer
  // ---------------------------------------------------------------
  seq_state_t state;
  logic [AW-1:0] curIdx;
  logic [AW-1:0] memAddr;
  logic [DW-1:0] memData;
  logic [AW-1:0] winAddr;
  logic [AW-1:0] holdIdx;

  // [RQ8] window slot offsets the readout start pointer
  assign winAddr = readPtr + AW'(paddr[5:2]);
  // [RQ7] single entry serves every step
  assign holdIdx = (fillPtr <= AW'(1)) ? '0 : curIdx;
  // bus readout wins only while the sequencer is not loading
  assign memAddr = (state == LOAD) ? holdIdx : winAddr;

  hold_table #(
    .DEPTH(list_seq_pkg::TABLE_DEPTH),
    .AW(AW),
    .DW(DW)
  ) u_table (
    .sys_clk(sys_clk),
    .wrEn(holdWr),
    .wrAddr(fillPtr),
    .wrData(pwdata[DW-1:0]),
    .rdAddr(memAddr),
    .rdData(memData)
  );

  // ---------------------------------------------------------------
  // apb answer: window reads wait until the memory holds the bus address
  // ---------------------------------------------------------------
  logic rdWin;
  logic memForBus;
  assign rdWin = inWindow && !pwrite;

  // memory output belongs to the bus unless the sequencer addressed it last edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      memForBus <= 1'b0;
    end else begin
      memForBus <= state != LOAD;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= (setup && !rdWin) || (psel && penable && !pready && rdWin && memForBus);
    end
  end

  logic mapped;
  always_comb begin
    mapped = inWindow;
    unique case (paddr)
      list_seq_pkg::CTRL_OFS, list_seq_pkg::CMD_OFS, list_seq_pkg::PASS_OFS,
      list_seq_pkg::SKIP_OFS, list_seq_pkg::HOLD_WR_OFS, list_seq_pkg::FILL_PTR_OFS,
      list_seq_pkg::RDPTR_OFS, list_seq_pkg::STATUS_OFS, list_seq_pkg::STEP_LEN_OFS: mapped = 1'b1;
      default: ;
    endcase
  end

  logic [AW:0] winLimit;
  assign winLimit = {1'b0, readPtr} + (AW+1)'(paddr[5:2]);
  // slots at or past the fill pointer read as zero
  logic winFilled;
  assign winFilled = winLimit < {1'b0, fillPtr};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (rdCycle || wrCycle) begin
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (setup || (psel && penable && !pready)) begin
      pslverr <= !mapped;
      prdata <= '0;
      if (!pwrite) begin
        unique case (paddr)
          // [RQ4] direction reads back
          list_seq_pkg::CTRL_OFS: prdata <= {30'h0, userOrder, direction == list_seq_pkg::DIR_DOWN};
          list_seq_pkg::PASS_OFS: prdata <= {24'h0, passCount};
          list_seq_pkg::SKIP_OFS: prdata <= {24'h0, skipCount};
          list_seq_pkg::FILL_PTR_OFS: prdata <= {22'h0, fillPtr};
          list_seq_pkg::RDPTR_OFS: prdata <= {22'h0, readPtr};
          list_seq_pkg::STATUS_OFS: prdata <= {22'h0, curIdx};
          list_seq_pkg::STEP_LEN_OFS: prdata <= {22'h0, stepCount};
          default: ;
        endcase
        // [RQ8] window slot data
        if (penable && rdWin && memForBus && winFilled) begin
          prdata <= {16'h0, memData};
        end
      end
    end else begin
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // step sequencer
  // ---------------------------------------------------------------
  logic [DW-1:0] tickLeft;
  logic [7:0] passDone;
  logic firstPass;
  logic tick;
  logic [AW-1:0] lastIdx;
  logic [AW-1:0] firstIdx;
  logic [AW-1:0] loopIdx;
  logic atEnd;
  logic fresh;

  assign lastIdx = stepCount - 1'b1;
  // [RQ1] order follows direction
  // [RQ3] same for both order sources
  assign firstIdx = (direction == list_seq_pkg::DIR_UP) ? '0 : lastIdx;
  assign atEnd = (direction == list_seq_pkg::DIR_UP) ? (curIdx == lastIdx) : (curIdx == '0);
  // [RQ15] later passes start past skipped steps
  // [RQ18] only in up direction
  assign loopIdx = (direction == list_seq_pkg::DIR_UP && {2'b0, skipCount} < stepCount) ?
                   AW'(skipCount) : firstIdx;

  time_base #(
    .PERIOD(TICK_PERIOD)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(state == LOAD),
    .tick(tick)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= IDLE;
      curIdx <= '0;
      tickLeft <= '0;
      passDone <= '0;
      firstPass <= 1'b0;
      fresh <= 1'b0;
    end else if (cmdReset || cmdClear || cmdStop) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE: begin
          // [RQ11] start at first step
          if (cmdRun && stepCount != '0) begin
            curIdx <= firstIdx;
            passDone <= '0;
            firstPass <= 1'b1;
            state <= LOAD;
          end
        end
        LOAD: begin
          // memory answers one edge after LOAD presents the address
          fresh <= 1'b1;
          state <= DWELL;
        end
        DWELL: begin
          if (fresh) begin
            // [RQ6] dwell of same index
            tickLeft <= memData;
            fresh <= 1'b0;
          // [RQ20] count ticks down to the step end
          end else if (tick && tickLeft > DW'(1)) begin
            tickLeft <= tickLeft - 1'b1;
          end else if (tick || tickLeft == '0) begin
            if (!atEnd) begin
              curIdx <= (direction == list_seq_pkg::DIR_UP) ? curIdx + 1'b1 : curIdx - 1'b1;
              state <= LOAD;
            // [RQ17] zero repeats forever
            end else if (passCount == '0 || passDone + 1'b1 < passCount) begin
              passDone <= passDone + 1'b1;
              firstPass <= 1'b0;
              // [RQ12] straight back to first step
              curIdx <= loopIdx;
              state <= LOAD;
            end else begin
              // [RQ13] hold last executed step
              // [RQ14] down ends on location 0
              state <= IDLE;
            end
          end
        end
      endcase
    end
  end

  // memory read for LOAD is issued while the state is LOAD, not while entering it
  // so LOAD presents address and the data arrives on the DWELL edge
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      stepIndex <= '0;
      stepStrobe <= 1'b0;
    end else begin
      running <= state != IDLE;
      stepIndex <= curIdx;
      // [RQ16] each step shown once per dwell
      stepStrobe <= state == LOAD;
    end
  end

  logic unusedFirst;
  assign unusedFirst = firstPass;
endmodule

// ==== verification/list_step_sequencer_chk.sv ====
// port checker for the list step sequencer
`timescale 1ns/1ps
module list_step_sequencer_chk #(
  parameter int TICK_PERIOD = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic running,
  input wire logic [9:0] stepIndex,
  input wire logic stepStrobe
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic cmdWr;
  assign cmdWr = psel && penable && pwrite && pready && (paddr == list_seq_pkg::CMD_OFS);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_runCmd;
    cmdWr && pwdata[list_seq_pkg::CMD_RUN_BIT] && !pwdata[list_seq_pkg::CMD_STOP_BIT];
  endsequence
  sequence s_firstStep;
    ##[1:40] (stepStrobe && running);
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_err_zero;
    (pready && pslverr && !pwrite) |-> (prdata == 32'h00000000);
  endproperty
  property p_strobe_pulse;
    stepStrobe |=> !stepStrobe;
  endproperty
  property p_strobe_running;
    stepStrobe |-> running;
  endproperty
  property p_run_start;
    s_runCmd |-> s_firstStep;
  endproperty
  property p_stop;
    (cmdWr && pwdata[list_seq_pkg::CMD_STOP_BIT]) |-> ##[1:4] !running;
  endproperty
  property p_hold_idle;
    (!running && !$past(running) && !$past(cmdWr)) |-> $stable(stepIndex);
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_ready_access: assert property (p_ready_access) else $error("pready outside access phase");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("step strobe too long");
  a_strobe_running: assert property (p_strobe_running) else $error("step strobe while idle");
  a_run_start: assert property (p_run_start) else $error("run did not start stepping");
  a_stop: assert property (p_stop) else $error("stop did not halt list");
  a_hold_idle: assert property (p_hold_idle) else $error("index moved while stopped");
endmodule
bind list_step_sequencer list_step_sequencer_chk #(.TICK_PERIOD(TICK_PERIOD)) i_list_step_sequencer_chk (.*);

// ==== verification/host_apb_model.sv ====
// host model issuing register commands over apb
`timescale 1ns/1ps
module host_apb_model (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int holdSent = 0;
  logic hung = 1'b0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int n;
    begin
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
        @(posedge sys_clk);
        n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) hung = 1'b1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data lines must not look like a held value
      pwdata <= ~d;
      if (w && a == list_seq_pkg::CMD_OFS && (d[list_seq_pkg::CMD_CLEAR_BIT] || d[list_seq_pkg::CMD_RESET_BIT]))
        holdSent = 0;
    end
  endtask
  task automatic putHold(input int ticks);
    logic [31:0] rd;
    logic err;
    begin
      if (ticks >= 1 && ticks <= 20000 && holdSent < 1002) begin
        xfer(1'b1, list_seq_pkg::HOLD_WR_OFS, ticks, rd, err);
        holdSent++;
      end
    end
  endtask
endmodule

// ==== verification/list_step_sequencer_tb_top.sv ====
// self-checking bench for the list step sequencer
`timescale 1ns/1ps
module list_step_sequencer_tb_top;
  localparam int TP = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, running, stepStrobe, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] stepIndex;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int expIdx[16];
  int dw[4];
  logic [9:0] seqIdx[$];
  int seqAt[$];
  list_step_sequencer #(.TICK_PERIOD(TP)) i_list_step_sequencer (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .running(running), .stepIndex(stepIndex), .stepStrobe(stepStrobe));
  host_apb_model i_host_apb_model (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial forever #2.5 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (stepStrobe === 1'b1) begin
      seqIdx.push_back(stepIndex);
      seqAt.push_back(cycles);
    end
    if (cycles == 60000 || i_host_apb_model.hung === 1'b1) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkRange(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host_apb_model.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
    i_host_apb_model.xfer(1'b0, a, 32'h00000000, rd, err);
    chk(nm, e, rd);
  endtask
  task automatic cmd(input int bitPos);
    wr(list_seq_pkg::CMD_OFS, 32'h00000001 << bitPos);
  endtask
  // one full run: step order, count, per-step time and final held index
  task automatic runCheck(input int n);
    int k;
    begin
      seqIdx.delete();
      seqAt.delete();
      cmd(list_seq_pkg::CMD_RUN_BIT);
      k = 0;
      while (running !== 1'b1 && k < 20) begin
        @(posedge sys_clk);
        k++;
      end
      while (running !== 1'b0 && k < 5000) begin
        @(posedge sys_clk);
        k++;
      end
      #1;
      chk("run ended", 32'h00000000, {31'h0, running});
      chk("step count", n, seqIdx.size());
      for (int i = 0; i < n; i++) chk("step index", expIdx[i], {22'h000000, seqIdx[i]});
      for (int i = 0; i + 1 < seqIdx.size(); i++)
        chkRange("step time", TP * dw[seqIdx[i] % 4] - 4, TP * dw[seqIdx[i] % 4] + 4, seqAt[i + 1] - seqAt[i]);
      chk("held index", expIdx[n - 1], {22'h000000, stepIndex});
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdChk("ctrl", list_seq_pkg::CTRL_OFS, 32'h00000000);
    rdChk("pass", list_seq_pkg::PASS_OFS, 32'h00000001);
    rdChk("skip", list_seq_pkg::SKIP_OFS, 32'h00000000);
    rdChk("fill", list_seq_pkg::FILL_PTR_OFS, 32'h00000000);
    wr(list_seq_pkg::CTRL_OFS, 32'h00000003);
    rdChk("ctrl", list_seq_pkg::CTRL_OFS, 32'h00000003);
    rdChk("unmapped", 12'h030, 32'h00000000);
    chk("slverr", 32'h00000001, {31'h0, err});
    cmd(list_seq_pkg::CMD_RESET_BIT);
    rdChk("ctrl", list_seq_pkg::CTRL_OFS, 32'h00000000);
    for (int i = 1; i <= 3; i++) i_host_apb_model.putHold(i);
    rdChk("fill", list_seq_pkg::FILL_PTR_OFS, 32'h00000003);
    wr(list_seq_pkg::RDPTR_OFS, 32'h00000002);
    wr(list_seq_pkg::PASS_OFS, 32'h00000005);
    wr(list_seq_pkg::CTRL_OFS, 32'h00000003);
    cmd(list_seq_pkg::CMD_CLEAR_BIT);
    rdChk("fill", list_seq_pkg::FILL_PTR_OFS, 32'h00000000);
    rdChk("rdptr", list_seq_pkg::RDPTR_OFS, 32'h00000000);
    rdChk("ctrl", list_seq_pkg::CTRL_OFS, 32'h00000000);
    rdChk("pass", list_seq_pkg::PASS_OFS, 32'h00000001);
    // single dwell at location 0 serves all four steps
    i_host_apb_model.putHold(2);
    dw = '{2, 2, 2, 2};
    wr(list_seq_pkg::STEP_LEN_OFS, 32'h00000004);
    wr(list_seq_pkg::PASS_OFS, 32'h00000002);
    for (int i = 0; i < 8; i++) expIdx[i] = i % 4;
    runCheck(8);
    wr(list_seq_pkg::CTRL_OFS, 32'h00000001);
    wr(list_seq_pkg::SKIP_OFS, 32'h00000001);
    rdChk("ctrl", list_seq_pkg::CTRL_OFS, 32'h00000001);
    for (int i = 0; i < 8; i++) expIdx[i] = 3 - (i % 4);
    runCheck(8);
    cmd(list_seq_pkg::CMD_CLEAR_BIT);
    for (int i = 1; i <= 4; i++) i_host_apb_model.putHold(i);
    dw = '{1, 2, 3, 4};
    wr(list_seq_pkg::STEP_LEN_OFS, 32'h00000004);
    wr(list_seq_pkg::PASS_OFS, 32'h00000002);
    wr(list_seq_pkg::SKIP_OFS, 32'h00000001);
    for (int i = 0; i < 7; i++) expIdx[i] = (i < 4) ? i : 1 + (i - 4) % 3;
    runCheck(7);
    rdChk("status", list_seq_pkg::STATUS_OFS, 32'h00000003);
    rdChk("window", list_seq_pkg::HOLD_RD_OFS + 12'h004, 32'h00000002);
    wr(list_seq_pkg::RDPTR_OFS, 32'h00000002);
    rdChk("window", list_seq_pkg::HOLD_RD_OFS + 12'h004, 32'h00000004);
    rdChk("window", list_seq_pkg::HOLD_RD_OFS + 12'h008, 32'h00000000);
    // pass count zero keeps cycling until stopped
    wr(list_seq_pkg::PASS_OFS, 32'h00000000);
    seqIdx.delete();
    cmd(list_seq_pkg::CMD_RUN_BIT);
    for (int k = 0; k < 3000 && seqIdx.size() < 12; k++) @(posedge sys_clk);
    #1;
    chk("endless", 32'h00000001, {31'h0, running});
    chkRange("endless steps", 12, 3000, seqIdx.size());
    cmd(list_seq_pkg::CMD_STOP_BIT);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("stopped", 32'h00000000, {31'h0, running});
    summarize();
  end
endmodule
